/* hw/tac_pkg.sv */
// How it works
// - Timer counts only while enable bit set
// - Idle-stop bit halts timer in idle mode
// - Write-disable drops count writes while pending
// - Pending flag high during async count write
// - Pending flag reads zero in sync mode
// - Gate bit counts while gate high, internal only
// - Prescale select divides by 1, 8, 64, 256
// - Unimplemented control bits read zero, ignore writes
package tac_pkg;
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  OFS_CONTROL  = 4'h0;
  localparam logic [3:0]  OFS_COUNT    = 4'h4;
  localparam logic [3:0]  OFS_PERIOD   = 4'h8;
  localparam int unsigned BIT_ENABLE   = 15;
  localparam int unsigned BIT_IDLE     = 13;
  localparam int unsigned BIT_WDIS     = 12;
  localparam int unsigned BIT_WIP      = 11;
  localparam int unsigned BIT_GATE     = 7;
  localparam int unsigned BIT_PS_HI    = 5;
  localparam int unsigned BIT_PS_LO    = 4;
  localparam int unsigned BIT_SYNC     = 2;
  localparam int unsigned BIT_CS       = 1;
  localparam logic [31:0] CTRL_WMASK   = 32'h0000_B0B6;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [7:0]  DIV_1        = 8'h00;
  localparam logic [7:0]  DIV_8        = 8'h07;
  localparam logic [7:0]  DIV_64       = 8'h3F;
  localparam logic [7:0]  DIV_256      = 8'hFF;
  localparam int unsigned ASYNC_WR_CYC = 3;

  typedef struct packed {
    logic       enable;
    logic       idle_stop;
    logic       async_write_disable;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } tac_ctrl_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_BUSY = 2'b01
  } tac_wr_e;

  // Terminal count of the prescaler for each select code
  function automatic logic [7:0] tac_div_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   tac_div_limit = DIV_1;
      2'b01:   tac_div_limit = DIV_8;
      2'b10:   tac_div_limit = DIV_64;
      default: tac_div_limit = DIV_256;
    endcase
  endfunction : tac_div_limit
endpackage : tac_pkg

/* hw/tac_timer.sv */
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tac_timer import tac_pkg::*; #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [31:0]            rdata,
  input  wire logic              idle_mode,
  input  wire logic              ext_clk_in,
  input  wire logic              gate_in,
  output logic                   period_match
);

  // ---------------------------------------------
  // Control register
  // ---------------------------------------------
  tac_ctrl_s             ctrl_reg, ctrl_next;
  logic [CNT_W-1:0]      count_reg, count_next;
  logic [CNT_W-1:0]      period_reg, period_next;
  logic [CNT_W-1:0]      wbuf_reg, wbuf_next;
  tac_wr_e               wst_reg, wst_next;
  logic [1:0]            wcnt_reg, wcnt_next;
  logic [7:0]            ps_reg, ps_next;
  logic                  ext_s1_reg, ext_s2_reg, ext_d_reg;
  logic                  match_reg, match_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [31:0]           ctrl_word;
  logic                  run, src_tick, tick, async_mode, wr_count, pending;

  assign async_mode = ctrl_reg.clock_source_select && !ctrl_reg.ext_clock_sync;
  assign pending    = (wst_reg == WR_BUSY);
  assign wr_count   = wr_en && (addr == OFS_COUNT);

  always_comb begin
    ctrl_word                  = CTRL_RESET;
    ctrl_word[BIT_ENABLE]      = ctrl_reg.enable;
    ctrl_word[BIT_IDLE]        = ctrl_reg.idle_stop;
    ctrl_word[BIT_WDIS]        = ctrl_reg.async_write_disable;
    ctrl_word[BIT_WIP]         = pending && async_mode;
    ctrl_word[BIT_GATE]        = ctrl_reg.gate_accumulate_enable;
    ctrl_word[BIT_PS_HI]       = ctrl_reg.prescale_select[1];
    ctrl_word[BIT_PS_LO]       = ctrl_reg.prescale_select[0];
    ctrl_word[BIT_SYNC]        = ctrl_reg.ext_clock_sync;
    ctrl_word[BIT_CS]          = ctrl_reg.clock_source_select;
  end

  // ---------------------------------------------
  // Clock source and gating
  // ---------------------------------------------
  // Source select; external edge found after synchroniser
  // External pin is always resynchronised; unsynced mode only changes write handling
  assign src_tick = ctrl_reg.clock_source_select ? (ext_s2_reg && !ext_d_reg) :
                    (!ctrl_reg.gate_accumulate_enable || gate_in);
  assign run  = ctrl_reg.enable && !(ctrl_reg.idle_stop && idle_mode);
  // Prescaler terminal count
  // Compare with >= so a smaller select never waits for the 8-bit prescaler to wrap
  assign tick = run && src_tick && (ps_reg >= tac_div_limit(ctrl_reg.prescale_select));

  always_comb begin
    ctrl_next   = ctrl_reg;
    period_next = period_reg;
    ps_next     = ps_reg;
    count_next  = count_reg;
    wbuf_next   = wbuf_reg;
    wst_next    = wst_reg;
    wcnt_next   = wcnt_reg;
    match_next  = 1'b0;
    rdata_next  = 32'h0000_0000;
    if (wr_en && addr == OFS_CONTROL) begin
      ctrl_next.enable                 = wdata[BIT_ENABLE];
      ctrl_next.idle_stop              = wdata[BIT_IDLE];
      ctrl_next.async_write_disable    = wdata[BIT_WDIS];
      ctrl_next.gate_accumulate_enable = wdata[BIT_GATE];
      ctrl_next.prescale_select        = wdata[BIT_PS_HI:BIT_PS_LO];
      ctrl_next.ext_clock_sync         = wdata[BIT_SYNC];
      ctrl_next.clock_source_select    = wdata[BIT_CS];
    end
    if (wr_en && addr == OFS_PERIOD)
      period_next = wdata[CNT_W-1:0];
    if (run && src_tick)
      ps_next = tick ? 8'h00 : ps_reg + 8'h01;
    if (tick) begin
      count_next = (count_reg == period_reg) ? '0 : count_reg + 1'b1;
      match_next = (count_reg == period_reg);
    end
    if (pending) begin
      if (wcnt_reg == 2'(ASYNC_WR_CYC - 1)) begin
        count_next = wbuf_reg;
        wst_next   = WR_IDLE;
      end else begin
        wcnt_next = wcnt_reg + 2'h1;
      end
    end
    if (wr_count) begin
      if (!async_mode) begin
        count_next = wdata[CNT_W-1:0];
        ps_next    = 8'h00;
      // Drop writes while pending if disabled
      end else if (!(pending && ctrl_reg.async_write_disable)) begin
        wbuf_next = wdata[CNT_W-1:0];
        wst_next  = WR_BUSY;
        wcnt_next = 2'h0;
      end
    end
    if (rd_en) begin
      case (addr)
        OFS_CONTROL: rdata_next = ctrl_word;
        OFS_COUNT:   rdata_next = 32'(count_reg);
        OFS_PERIOD:  rdata_next = 32'(period_reg);
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg   <= '0;
      period_reg <= PERIOD_RESET;
      ps_reg     <= 8'h00;
      count_reg  <= '0;
      wbuf_reg   <= '0;
      wst_reg    <= WR_IDLE;
      wcnt_reg   <= 2'h0;
      match_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg  <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      period_reg <= period_next;
      ps_reg     <= ps_next;
      count_reg  <= count_next;
      wbuf_reg   <= wbuf_next;
      wst_reg    <= wst_next;
      wcnt_reg   <= wcnt_next;
      match_reg  <= match_next;
      rdata_reg  <= rdata_next;
      ext_s1_reg <= ext_clk_in;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg  <= ext_s2_reg;
    end
  end

  assign rdata        = rdata_reg;
  assign period_match = match_reg;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------
  // Run control checks
  // ---------------------------------------------
  // Hold when off
  a_hold_when_off: assert property (!ctrl_reg.enable && !pending && !wr_count
    |=> count_reg == $past(count_reg)) else $error("count moved while disabled");
  a_no_tick_off: assert property (
    !ctrl_reg.enable |-> !tick)
    else $error("tick while disabled");
  a_ps_hold_off: assert property (
    !run && !wr_count |=> ps_reg == $past(ps_reg))
    else $error("prescaler moved while stopped");
  a_idle_halt: assert property (ctrl_reg.idle_stop && idle_mode |-> !tick)
    else $error("tick during idle stop");
  a_idle_run: assert property (
    ctrl_reg.enable && !ctrl_reg.idle_stop |-> run)
    else $error("stopped in idle without idle stop");
  a_idle_hold: assert property (ctrl_reg.idle_stop && idle_mode && !pending && !wr_count
    |=> count_reg == $past(count_reg))
    else $error("count moved during idle stop");

  // ---------------------------------------------
  // Count write checks
  // ---------------------------------------------
  // Dropped write
  a_write_drop: assert property (wr_count && async_mode && pending && ctrl_reg.async_write_disable
    |=> wbuf_reg == $past(wbuf_reg)) else $error("write not ignored");
  a_write_take: assert property (wr_count && async_mode && !ctrl_reg.async_write_disable
    |=> pending && wbuf_reg == CNT_W'($past(wdata)))
    else $error("async write not accepted");
  a_drop_count: assert property (wr_count && async_mode && pending && ctrl_reg.async_write_disable
    && wcnt_reg != 2'(ASYNC_WR_CYC - 1) |=> pending)
    else $error("dropped write ended pending write");
  a_pend_flag: assert property (pending && wcnt_reg == 2'(ASYNC_WR_CYC - 1) && !(wr_count && async_mode)
    |=> !pending) else $error("async write never completes");
  a_pend_set: assert property (wr_count && async_mode && !(pending && ctrl_reg.async_write_disable)
    |=> pending)
    else $error("accepted async write not pending");
  a_pend_load: assert property (pending && wcnt_reg == 2'(ASYNC_WR_CYC - 1) && !wr_count
    |=> count_reg == $past(wbuf_reg))
    else $error("pending write not loaded");
  a_pend_read: assert property (rd_en && addr == OFS_CONTROL && async_mode && pending
    |=> rdata[BIT_WIP])
    else $error("pending flag not shown");
  a_pend_sync: assert property (rd_en && addr == OFS_CONTROL && !async_mode
    |=> !rdata[BIT_WIP]) else $error("pending flag set in sync mode");
  a_sync_direct: assert property (
    wr_count && !async_mode |=> count_reg == CNT_W'($past(wdata)))
    else $error("sync count write not immediate");

  // ---------------------------------------------
  // Clock source and prescaler checks
  // ---------------------------------------------
  // Gate low stops
  a_gate_low: assert property (run && !ctrl_reg.clock_source_select
    && ctrl_reg.gate_accumulate_enable && !gate_in |-> !tick) else $error("gate ignored");
  a_gate_high: assert property (run && !ctrl_reg.clock_source_select && gate_in
    && ctrl_reg.prescale_select == 2'b00 |-> tick)
    else $error("gate high missed tick");
  a_gate_ext: assert property (run && ctrl_reg.clock_source_select && ext_s2_reg && !ext_d_reg
    && ctrl_reg.prescale_select == 2'b00 |-> tick)
    else $error("external edge missed");
  a_div_one: assert property (run && src_tick && ctrl_reg.prescale_select == 2'b00 |-> tick)
    else $error("1:1 prescale missed tick");
  a_ps_clear: assert property (
    tick |=> ps_reg == 8'h00)
    else $error("prescaler not cleared on tick");
  a_ps_step: assert property (
    run && src_tick && !tick && !wr_count |=> ps_reg == $past(ps_reg) + 8'h01)
    else $error("prescaler step wrong");
  a_int_source: assert property (
    run && !ctrl_reg.clock_source_select && !ctrl_reg.gate_accumulate_enable |-> src_tick)
    else $error("internal source missing");
  a_ext_source: assert property (
    ctrl_reg.clock_source_select && !(ext_s2_reg && !ext_d_reg) |-> !tick)
    else $error("tick without external edge");

  // ---------------------------------------------
  // Register and count checks
  // ---------------------------------------------
  // Unused read zero
  a_unimpl_zero: assert property (rd_en |=> (rdata & ~(CTRL_WMASK | 32'h0000_0800)) == 32'h0
    || $past(addr) != OFS_CONTROL) else $error("unimplemented bit set");
  a_ctrl_unimpl: assert property (
    (ctrl_word & ~(CTRL_WMASK | 32'h0000_0800)) == 32'h0000_0000)
    else $error("control view has unused bit");
  a_ctrl_write: assert property (wr_en && addr == OFS_CONTROL
    |=> (ctrl_word & CTRL_WMASK) == ($past(wdata) & CTRL_WMASK))
    else $error("control write lost");
  a_count_step: assert property (tick && !pending && !wr_count && count_reg != period_reg
    |=> count_reg == $past(count_reg) + 1'b1) else $error("count step wrong");
  a_wrap: assert property (tick && !pending && !wr_count && count_reg == period_reg
    |=> count_reg == '0 && period_match)
    else $error("wrap at period wrong");
  a_match_only: assert property (
    period_match |-> $past(tick))
    else $error("match without tick");
  a_period_write: assert property (
    wr_en && addr == OFS_PERIOD |=> period_reg == CNT_W'($past(wdata)))
    else $error("period write lost");

  c_async_wr: cover property (wr_count && async_mode ##1 pending [*2] ##1 !pending);
  c_wrap: cover property (period_match);
  c_div256: cover property (tick && ctrl_reg.prescale_select == 2'b11);
  c_drop: cover property (wr_count && pending && ctrl_reg.async_write_disable);
  c_gate: cover property (tick && ctrl_reg.gate_accumulate_enable && !ctrl_reg.clock_source_select);

endmodule : tac_timer
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import tac_pkg::*;;
  localparam logic [31:0] C_EN   = 32'h0000_8000;
  localparam logic [31:0] C_IDLE = 32'h0000_2000;
  localparam logic [31:0] C_WDIS = 32'h0000_1000;
  localparam logic [31:0] C_PEND = 32'h0000_0800;
  localparam logic [31:0] C_GATE = 32'h0000_0080;
  localparam logic [31:0] C_SYNC = 32'h0000_0004;
  localparam logic [31:0] C_EXT  = 32'h0000_0002;

  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic              idle_mode = 1'b0;
  logic              ext_clk_in = 1'b0;
  logic              gate_in = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [31:0]       wdata = 32'h0000_0000;
  logic [31:0]       rdata;
  logic              period_match;
  logic [31:0]       a;
  logic [31:0]       b;
  logic [31:0]       d;
  int                failures = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #12.5 clk = ~clk;

  tac_timer #(.CNT_W(16)) dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .idle_mode(idle_mode), .ext_clk_in(ext_clk_in), .gate_in(gate_in),
    .period_match(period_match));

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge clk);
    addr <= ad;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [31:0] v);
    @(posedge clk);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Count advance over exactly n clocks, sampling edges n apart
  task automatic rate(input int n, output logic [31:0] v);
    rd(OFS_COUNT, a);
    repeat (n - 3) @(posedge clk);
    rd(OFS_COUNT, b);
    v = {16'h0000, b[15:0] - a[15:0]};
  endtask : rate

  // Slow external edges so the input synchroniser sees every one
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk_in <= 1'b1;
      repeat (2) @(posedge clk);
      ext_clk_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic give_verdict;
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CONTROL, d); chk(d, 32'h0000_0000);
    rd(OFS_COUNT, d); chk(d, 32'h0000_0000);
    rd(4'hC, d); chk(d, 32'h0000_0000);
    wr(OFS_CONTROL, 32'hFFFF_FFFF);
    rd(OFS_CONTROL, d); chk(d, 32'h0000_B0B6);
    wr(OFS_CONTROL, 32'h0000_0000);
    @(posedge clk);
    rate(20, d); chk(d, 32'd0);
    wr(OFS_CONTROL, C_EN);
    rate(20, d); chk(d, 32'd20);
    for (int i = 1; i < 4; i++) begin
      wr(OFS_CONTROL, C_EN | (32'(i) << 4));
      rate((i == 1) ? 16 : (i == 2) ? 128 : 512, d); chk(d, 32'd2);
    end
    idle_mode <= 1'b1;
    wr(OFS_CONTROL, C_EN | C_IDLE);
    rate(20, d); chk(d, 32'd0);
    wr(OFS_CONTROL, C_EN);
    rate(20, d); chk(d, 32'd20);
    idle_mode <= 1'b0;
    wr(OFS_CONTROL, C_EN | C_GATE);
    rate(20, d); chk(d, 32'd0);
    gate_in <= 1'b1;
    repeat (4) @(posedge clk);
    rate(20, d); chk(d, 32'd20);
    gate_in <= 1'b0;
    // Gate low must not stop the external source
    wr(OFS_CONTROL, C_EN | C_GATE | C_SYNC | C_EXT);
    wr(OFS_COUNT, 32'h0000_0000);
    pulse(5);
    rd(OFS_COUNT, d); chk(d, 32'd5);
    wr(OFS_COUNT, 32'h0000_0007);
    rd(OFS_CONTROL, d); chk(d, C_EN | C_GATE | C_SYNC | C_EXT);
    wr(OFS_CONTROL, C_EN | C_EXT);
    wr(OFS_COUNT, 32'h0000_0055);
    rd(OFS_CONTROL, d); chk(d, C_EN | C_EXT | C_PEND);
    repeat (4) @(posedge clk);
    rd(OFS_CONTROL, d); chk(d, C_EN | C_EXT);
    rd(OFS_COUNT, d); chk(d, 32'h0000_0055);
    wr(OFS_CONTROL, C_EN | C_EXT | C_WDIS);
    wr(OFS_COUNT, 32'h0000_0011);
    wr(OFS_COUNT, 32'h0000_0022);
    repeat (6) @(posedge clk);
    rd(OFS_COUNT, d); chk(d, 32'h0000_0011);
    wr(OFS_CONTROL, C_EN | C_EXT);
    wr(OFS_COUNT, 32'h0000_0033);
    wr(OFS_COUNT, 32'h0000_0044);
    repeat (6) @(posedge clk);
    rd(OFS_COUNT, d); chk(d, 32'h0000_0044);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CONTROL, d); chk(d, 32'h0000_0000);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
